// File: common/tfr_pkg.sv
package tfr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Byte offsets of the register map
  localparam logic [7:0] A_LOCAL_TEMP   = 8'h00;
  localparam logic [7:0] A_RTEMP_HI     = 8'h01;
  localparam logic [7:0] A_STATUS       = 8'h02;
  localparam logic [7:0] A_CONFIG       = 8'h03;
  localparam logic [7:0] A_CONV_RATE    = 8'h04;
  localparam logic [7:0] A_LOCAL_HIGH   = 8'h05;
  localparam logic [7:0] A_RHIGH_HI     = 8'h07;
  localparam logic [7:0] A_RLOW_HI      = 8'h08;
  localparam logic [7:0] A_CONFIG_ALIAS = 8'h09;
  localparam logic [7:0] A_CONV_ALIAS   = 8'h0a;
  localparam logic [7:0] A_LHIGH_ALIAS  = 8'h0b;
  localparam logic [7:0] A_RHIGH_ALIAS  = 8'h0d;
  localparam logic [7:0] A_RLOW_ALIAS   = 8'h0e;
  localparam logic [7:0] A_ONE_SHOT     = 8'h0f;
  localparam logic [7:0] A_RTEMP_LO     = 8'h10;
  localparam logic [7:0] A_ROFF_HI      = 8'h11;
  localparam logic [7:0] A_ROFF_LO      = 8'h12;
  localparam logic [7:0] A_RHIGH_LO     = 8'h13;
  localparam logic [7:0] A_RLOW_LO      = 8'h14;
  localparam logic [7:0] A_ALERT_MASK   = 8'h16;
  localparam logic [7:0] A_RCRIT        = 8'h19;
  localparam logic [7:0] A_RCRIT_HYST   = 8'h21;
  localparam logic [7:0] A_TACH_CNT_LO  = 8'h46;
  localparam logic [7:0] A_TACH_CNT_HI  = 8'h47;
  localparam logic [7:0] A_TACH_LIM_LO  = 8'h48;
  localparam logic [7:0] A_TACH_LIM_HI  = 8'h49;
  localparam logic [7:0] A_FAN_DRIVE    = 8'h4a;
  localparam logic [7:0] A_SPINUP       = 8'h4b;
  localparam logic [7:0] A_DUTY         = 8'h4c;
  localparam logic [7:0] A_DUTY_FREQ    = 8'h4d;
  localparam logic [7:0] A_LUT_HYST     = 8'h4f;
  localparam logic [7:0] A_LUT_BASE     = 8'h50;
  localparam logic [7:0] A_FILTER       = 8'hbf;
  localparam logic [7:0] A_MAKER_ID     = 8'hfe;
  localparam logic [7:0] A_REVISION     = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes, field positions and masks
  localparam int         NRW        = 19;
  localparam int         LUT_SLOTS  = 16;
  localparam int         CFG_STANDBY   = 6;
  localparam int         FAN_DUTY_PROG = 5;
  localparam int         FILT_CMP      = 0;
  localparam int         FILT_LVL_LO   = 1;
  localparam int         FILT_LVL_HI   = 2;
  localparam int         LIMIT_SIGN    = 7;
  localparam logic [7:0] M_FULL     = 8'hff;
  localparam logic [7:0] M_FRACTION = 8'he0;
  localparam logic [7:0] M_STATUS   = 8'hdf;
  localparam logic [7:0] M_SIX_BIT  = 8'h3f;
  localparam logic [7:0] M_FIVE_BIT = 8'h1f;
  localparam logic [7:0] DUTY_RESET = 8'h00;

  // Indices into the writable register table
  localparam int I_CONFIG    = 0;
  localparam int I_RLOW_HI   = 4;
  localparam int I_RHIGH_LO  = 7;
  localparam int I_FAN_DRIVE = 14;
  localparam int I_FILTER    = 18;

  // Writable registers: address, alias, write mask, forced ones, reset
  localparam logic [7:0] RW_ADDR [NRW] = '{A_CONFIG, A_CONV_RATE, A_LOCAL_HIGH,
    A_RHIGH_HI, A_RLOW_HI, A_ROFF_HI, A_ROFF_LO, A_RHIGH_LO, A_RLOW_LO,
    A_ALERT_MASK, A_RCRIT, A_RCRIT_HYST, A_TACH_LIM_LO, A_TACH_LIM_HI,
    A_FAN_DRIVE, A_SPINUP, A_DUTY_FREQ, A_LUT_HYST, A_FILTER};
  localparam logic [7:0] RW_ALIAS [NRW] = '{A_CONFIG_ALIAS, A_CONV_ALIAS,
    A_LHIGH_ALIAS, A_RHIGH_ALIAS, A_RLOW_ALIAS, A_ROFF_HI, A_ROFF_LO,
    A_RHIGH_LO, A_RLOW_LO, A_ALERT_MASK, A_RCRIT, A_RCRIT_HYST, A_TACH_LIM_LO,
    A_TACH_LIM_HI, A_FAN_DRIVE, A_SPINUP, A_DUTY_FREQ, A_LUT_HYST, A_FILTER};
  localparam logic [7:0] RW_MASK [NRW] = '{8'he7, 8'h0f, M_FULL, M_FULL,
    M_FULL, M_FULL, M_FRACTION, M_FRACTION, M_FRACTION, 8'h5b, M_FULL,
    M_FULL, 8'hfc, M_FULL, 8'h3b, M_SIX_BIT, M_FIVE_BIT, M_FIVE_BIT, 8'h07};
  localparam logic [7:0] RW_ONES [NRW] = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha4, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RW_RST [NRW] = '{8'h00, 8'h08, 8'h46, 8'h46,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha4, 8'h55, 8'h0a, 8'hfc, 8'hff,
    8'h20, 8'h3f, 8'h17, 8'h04, 8'h00};

endpackage : tfr_pkg

// File: common/tfr_reg_if.sv
// Internal write path shared by all byte registers
interface tfr_reg_if;
  logic       en;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;

  modport host (output en, output wr, output addr, output wdata);
  modport sink (input en, input wr, input addr, input wdata);
endinterface : tfr_reg_if

// File: hw/tfr_byte_reg.sv
module tfr_byte_reg #(
  parameter logic [7:0] ADDR  = 8'h00,
  parameter logic [7:0] ALIAS = 8'h00,
  parameter logic [7:0] WMASK = 8'hff,
  parameter logic [7:0] ONES  = 8'h00,
  parameter logic [7:0] RSTV  = 8'h00
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  tfr_reg_if.sink         bus,
  output      logic       hit,
  output      logic [7:0] q
);

  // Forced-one bits must also be one at reset
  if ((RSTV & ONES) != ONES) begin : g_bad_reset
    $error("tfr_byte_reg reset value clears a forced-one bit");
  end

  // primary and alias address share storage
  assign hit = (bus.addr == ADDR) || (bus.addr == ALIAS);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= RSTV & (WMASK | ONES);
    end else if (bus.en && bus.wr && hit) begin
      q <= (bus.wdata & WMASK) | ONES;
    end
  end

endmodule : tfr_byte_reg

// File: hw/tfr_register_map.sv
module tfr_register_map
  import tfr_pkg::*;
#(
  parameter int         LUT_DEPTH = tfr_pkg::LUT_SLOTS,
  parameter logic [7:0] MAKER_ID  = 8'h5a,  // Arbitrary value
  parameter logic [7:0] REVISION  = 8'h3c   // Arbitrary value
) (
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  input  wire logic [7:0]             reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_rd,
  output      logic [7:0]             reg_rdata,
  output      logic                   reg_hit,
  input  wire logic                   sample_strobe,
  input  wire logic [7:0]             local_temp_in,
  input  wire logic [7:0]             remote_temp_hi_in,
  input  wire logic [7:0]             remote_temp_lo_in,
  input  wire logic [7:0]             alert_status_in,
  input  wire logic [7:0]             tach_count_lo_in,
  input  wire logic [7:0]             tach_count_hi_in,
  input  wire logic [7:0]             duty_auto_in,
  output      logic                   conversion_start,
  output      logic                   standby,
  output      logic                   duty_override,
  output      logic [7:0]             duty_value,
  output      logic [1:0]             filter_level,
  output      logic                   alert_comparator_mode,
  output      logic                   remote_low_limit_sign,
  output      logic                   remote_high_limit_fraction_msb,
  output      logic [tfr_pkg::NRW*8-1:0] rw_image,
  output      logic [LUT_DEPTH*8-1:0] lut_image
);
  import tfr_pkg::*;

  // Lookup table must fit its sixteen-byte window
  if (LUT_DEPTH < 1 || LUT_DEPTH > LUT_SLOTS) begin : g_bad_depth
    $error("tfr_register_map LUT_DEPTH out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal write path
  tfr_reg_if bus ();

  assign bus.en    = clk_en;
  assign bus.wr    = reg_wr;
  assign bus.addr  = reg_addr;
  assign bus.wdata = reg_wdata;

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers and their aliases

  logic [7:0] rw_q   [NRW];
  logic [NRW-1:0] rw_hit;
  logic [7:0] rw_term [NRW];

  // alias pairs come from the address table
  for (genvar i = 0; i < NRW; i++) begin : g_rw
    tfr_byte_reg #(
      .ADDR  (RW_ADDR[i]),
      .ALIAS (RW_ALIAS[i]),
      .WMASK (RW_MASK[i]),
      .ONES  (RW_ONES[i]),
      .RSTV  (RW_RST[i])
    ) u_reg (
      .mclk    (mclk),
      .reset_n (reset_n),
      .bus     (bus),
      .hit     (rw_hit[i]),
      .q       (rw_q[i])
    );
    assign rw_term[i]           = rw_hit[i] ? rw_q[i] : 8'h00;
    assign rw_image[i*8 +: 8]   = rw_q[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fan lookup table

  logic [7:0] lut_q   [LUT_DEPTH];
  logic [LUT_DEPTH-1:0] lut_hit;
  logic [7:0] lut_term [LUT_DEPTH];

  for (genvar j = 0; j < LUT_DEPTH; j++) begin : g_lut
    tfr_byte_reg #(
      .ADDR  (8'(A_LUT_BASE + j)),
      .ALIAS (8'(A_LUT_BASE + j)),
      .WMASK (M_FULL),
      .ONES  (8'h00),
      .RSTV  (8'h00)
    ) u_reg (
      .mclk    (mclk),
      .reset_n (reset_n),
      .bus     (bus),
      .hit     (lut_hit[j]),
      .q       (lut_q[j])
    );
    assign lut_term[j]          = lut_hit[j] ? lut_q[j] : 8'h00;
    assign lut_image[j*8 +: 8]  = lut_q[j];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measured values from the conversion engine

  logic [7:0] local_q;
  logic [7:0] rtemp_hi_q;
  logic [7:0] rtemp_lo_q;
  logic [7:0] status_q;
  logic [7:0] tach_lo_q;
  logic [7:0] tach_hi_q;

  // fixed-zero bits are masked at capture
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      local_q    <= 8'h00;
      rtemp_hi_q <= 8'h00;
      rtemp_lo_q <= 8'h00;
      status_q   <= 8'h00;
      tach_lo_q  <= 8'h00;
      tach_hi_q  <= 8'h00;
    end else if (clk_en && sample_strobe) begin
      local_q    <= local_temp_in;
      rtemp_hi_q <= remote_temp_hi_in;
      rtemp_lo_q <= remote_temp_lo_in & M_FRACTION;
      status_q   <= alert_status_in & M_STATUS;
      tach_lo_q  <= tach_count_lo_in;
      tach_hi_q  <= tach_count_hi_in & M_SIX_BIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty value: follows the fan logic unless software takes over

  logic [7:0] duty_q;
  logic       duty_wr;

  assign duty_override = rw_q[I_FAN_DRIVE][FAN_DUTY_PROG];
  assign duty_wr       = clk_en && reg_wr && (reg_addr == A_DUTY);

  // Writes are dropped while the fan logic owns the value
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      duty_q <= DUTY_RESET;
    end else if (duty_override && duty_wr) begin
      duty_q <= reg_wdata & M_SIX_BIT;
    end else if (!duty_override && clk_en && sample_strobe) begin
      duty_q <= duty_auto_in & M_SIX_BIT;
    end
  end

  assign duty_value = duty_q;

  ////////////////////////////////////////////////////////////////////////////
  // One-shot trigger

  logic oneshot_hit;
  logic start_q;

  assign standby     = rw_q[I_CONFIG][CFG_STANDBY];
  assign oneshot_hit = reg_addr == A_ONE_SHOT;

  // pulse only in standby; running mode converts on its own
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      start_q <= 1'b0;
    end else if (clk_en) begin
      start_q <= reg_wr && oneshot_hit && standby;
    end
  end

  assign conversion_start = start_q;

  ////////////////////////////////////////////////////////////////////////////
  // Named fields for the rest of the device

  // filter level and comparator mode fields
  assign filter_level          = {rw_q[I_FILTER][FILT_LVL_HI], rw_q[I_FILTER][FILT_LVL_LO]};
  assign alert_comparator_mode = rw_q[I_FILTER][FILT_CMP];
  // sign of the left-justified lower limit
  assign remote_low_limit_sign = rw_q[I_RLOW_HI][LIMIT_SIGN];
  // top fraction bit of the upper limit
  assign remote_high_limit_fraction_msb = rw_q[I_RHIGH_LO][LIMIT_SIGN];

  ////////////////////////////////////////////////////////////////////////////
  // Read selection

  logic [7:0] rw_sel;
  logic [7:0] lut_sel;
  logic [7:0] ro_sel;
  logic       ro_hit;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  // Hits are exclusive, so an OR of the gated terms is the mux
  always_comb begin
    rw_sel  = 8'h00;
    lut_sel = 8'h00;
    for (int k = 0; k < NRW; k++) begin
      rw_sel = rw_sel | rw_term[k];
    end
    for (int m = 0; m < LUT_DEPTH; m++) begin
      lut_sel = lut_sel | lut_term[m];
    end
  end

  always_comb begin
    ro_hit = 1'b1;
    case (reg_addr)
      A_LOCAL_TEMP:  ro_sel = local_q;
      A_RTEMP_HI:    ro_sel = rtemp_hi_q;
      A_STATUS:      ro_sel = status_q;
      A_RTEMP_LO:    ro_sel = rtemp_lo_q;
      A_TACH_CNT_LO: ro_sel = tach_lo_q;
      A_TACH_CNT_HI: ro_sel = tach_hi_q;
      A_DUTY:        ro_sel = duty_q;
      A_ONE_SHOT:    ro_sel = 8'h00;
      A_MAKER_ID:    ro_sel = MAKER_ID;
      A_REVISION:    ro_sel = REVISION;
      default: begin
        ro_sel = 8'h00;
        ro_hit = 1'b0;
      end
    endcase
  end

  // reserved addresses hit nothing and read zero
  assign reg_hit = ro_hit || (|rw_hit) || (|lut_hit);
  assign rdata_d = ro_sel | rw_sel | lut_sel;

  // Read data is held until the next read
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (clk_en && reg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // A plain read of one address
  sequence s_read(logic [7:0] a);
    clk_en && reg_rd && !reg_wr && (reg_addr == a);
  endsequence

  // A write of a given address
  sequence s_write(logic [7:0] a);
    clk_en && reg_wr && (reg_addr == a);
  endsequence

  // Write, one cycle with no write taken, then a read of a given address, which may be the written one
  sequence s_write_then_read(logic [7:0] wa, logic [7:0] ra);
    s_write(wa) ##1 !(clk_en && reg_wr) ##1 s_read(ra);
  endsequence

  // One-shot in standby with no second one-shot right behind it
  sequence s_lone_shot;
    s_write(A_ONE_SHOT) ##0 standby
      ##1 (clk_en && !(reg_wr && (reg_addr == A_ONE_SHOT)));
  endsequence

  a_alias_config_mirror: assert property (
    s_write_then_read(A_CONFIG_ALIAS, A_CONFIG)
      |=> reg_rdata == ($past(reg_wdata, 3) & 8'he7))
    else $error("config alias write not seen at primary");

  a_alias_low_limit: assert property (
    s_write_then_read(A_RLOW_HI, A_RLOW_ALIAS)
      |=> reg_rdata == $past(reg_wdata, 3))
    else $error("low limit primary write not seen at alias");

  // Remaining alias pairs, each in the direction the host exercises
  a_alias_rate_mirror: assert property (
    s_write_then_read(A_CONV_ALIAS, A_CONV_RATE)
      |=> reg_rdata == ($past(reg_wdata, 3) & 8'h0f))
    else $error("rate alias write not seen at primary");

  a_alias_local_high: assert property (
    s_write_then_read(A_LOCAL_HIGH, A_LHIGH_ALIAS)
      |=> reg_rdata == $past(reg_wdata, 3))
    else $error("local limit primary write not seen at alias");

  a_alias_remote_high: assert property (
    s_write_then_read(A_RHIGH_ALIAS, A_RHIGH_HI)
      |=> reg_rdata == $past(reg_wdata, 3))
    else $error("remote limit alias write not seen at primary");

  a_reserved_reads_zero: assert property (
    clk_en && reg_rd && !reg_hit |=> reg_rdata == 8'h00)
    else $error("reserved address returned nonzero data");

  a_reserved_write_inert: assert property (
    clk_en && reg_wr && !reg_hit |=> $stable(rw_image) && $stable(lut_image))
    else $error("reserved address write changed a register");

  a_high_fraction_bits: assert property (
    s_read(A_RHIGH_LO)
      |=> reg_rdata[4:0] == 5'h00
          && reg_rdata[7] == remote_high_limit_fraction_msb)
    else $error("high limit low byte fraction layout wrong");

  a_low_limit_sign: assert property (
    s_write(A_RLOW_ALIAS) |=> remote_low_limit_sign == $past(reg_wdata[7]))
    else $error("low limit sign does not follow bit 15");

  a_filter_fields: assert property (
    s_read(A_FILTER)
      |=> reg_rdata == {5'h00, filter_level, alert_comparator_mode})
    else $error("filter register layout wrong");

  a_oneshot_pulse: assert property (
    s_lone_shot |-> conversion_start ##1 !conversion_start)
    else $error("one-shot did not give a single pulse");

  a_oneshot_idle: assert property (
    s_write(A_ONE_SHOT) ##0 !standby |=> !conversion_start)
    else $error("one-shot outside standby gave a pulse");

  a_oneshot_reads_zero: assert property (
    s_read(A_ONE_SHOT) |=> reg_rdata == 8'h00)
    else $error("one-shot address read nonzero");

  a_mask_fixed_ones: assert property (
    s_write_then_read(A_ALERT_MASK, A_ALERT_MASK)
      |=> reg_rdata == (($past(reg_wdata, 3) & 8'h5b) | 8'ha4))
    else $error("alert mask constant bits not held");

  // Unused low bits read back as zero
  a_low_fraction_bits: assert property (
    s_read(A_RLOW_LO) |=> reg_rdata[4:0] == 5'h00)
    else $error("low limit low byte unused bits nonzero");

  a_tach_limit_bits: assert property (
    s_read(A_TACH_LIM_LO) |=> reg_rdata[1:0] == 2'h0)
    else $error("tach limit unused bits nonzero");

endmodule : tfr_register_map

// File: verif/tfr_host_model.sv
// Register host standing in for the bus engine in front of the map
module tfr_host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_hit,
  output      logic [7:0] reg_addr,
  output      logic       reg_wr,
  output      logic [7:0] reg_wdata,
  output      logic       reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;

  // Quiet bus from time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // any address the caller gives, documented or not
  // Stray addresses come only from the caller as deliberate probes
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr  = a;
    reg_wdata = d;
    reg_rd    = 1'b0;
    reg_wr    = 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    reg_wr    = 1'b0;
    // Stale data inverted so a late sample cannot pass by luck
    reg_wdata = ~d;
  endtask : write_reg

  // Hit sampled at the taking edge, data at the falling edge half a cycle later
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(negedge mclk);
    reg_addr = a;
    reg_wr   = 1'b0;
    reg_rd   = 1'b1;
    @(posedge mclk);
    h = reg_hit;
    @(negedge mclk);
    reg_rd = 1'b0;
    d      = reg_rdata;
  endtask : read_reg
endmodule : tfr_host_model

// File: verif/tfr_register_map_tb_top.sv
module tfr_register_map_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // Row digits: {write, hit}, write address, write data, read address, expected
  typedef struct packed {
    logic       w;
    logic       hit;
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] ra;
    logic [7:0] exp;
  } tfr_row_type;

  logic       mclk          = 1'b0;
  logic       reset_n       = 1'b0;
  logic       clk_en        = 1'b1;
  logic       sample_strobe = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, duty_value;
  logic       reg_wr, reg_rd, reg_hit, hit, conversion_start, standby, duty_override;
  logic       alert_comparator_mode, remote_low_limit_sign, remote_high_limit_fraction_msb;
  logic [1:0] filter_level;
  logic [tfr_pkg::NRW*8-1:0] rw_img;
  logic [127:0] lut_img;
  logic [7:0] lt_in = 8'h00, rh_in = 8'h00, rl_in = 8'h00, st_in = 8'h00;
  logic [7:0] tl_in = 8'h00, th_in = 8'h00, du_in = 8'h00;
  int         n_errors    = 0;
  int         check_count = 0;
  int         cycles      = 0;

  tfr_row_type rows [75] = '{
    34'h1_00000300, 34'h1_00000900, 34'h1_00000408, 34'h1_00000a08,
    34'h1_00000546, 34'h1_00000b46, 34'h1_00000746, 34'h1_00000d46,
    34'h1_00000800, 34'h1_00000e00, 34'h1_00001100, 34'h1_00001200,
    34'h1_00001300, 34'h1_00001400, 34'h1_000016a4, 34'h1_00001955,
    34'h1_0000210a, 34'h1_000048fc, 34'h1_000049ff, 34'h1_00004a20,
    34'h1_00004b3f, 34'h1_00004c00, 34'h1_00004d17, 34'h1_00004f04,
    34'h1_00005000, 34'h1_0000bf00, 34'h1_00000f00, 34'h1_0000fe6e,
    34'h1_0000ff93,
    34'h3_09ff03e7, 34'h3_0aff040f, 34'h3_05a50ba5, 34'h3_0d3c073c,
    34'h3_08810e81, 34'h3_11c311c3, 34'h3_12ff12e0, 34'h3_13ff13e0,
    34'h3_14ff14e0, 34'h3_160016a4, 34'h3_197f197f, 34'h3_21122112,
    34'h3_48ff48fc, 34'h3_495a495a, 34'h3_4bff4b3f, 34'h3_4cff4c3f,
    34'h3_4aff4a3b, 34'h3_4dff4d1f, 34'h3_4fff4f1f, 34'h3_50a550a5,
    34'h3_5f3c5f3c, 34'h3_bfffbf07, 34'h3_0f550f00,
    34'h2_06ff0600, 34'h2_0cff0c00, 34'h2_15ff1500, 34'h2_17ff1700,
    34'h2_18ff1800, 34'h2_1aff1a00, 34'h2_1fff1f00, 34'h2_20ff2000,
    34'h2_22ff2200, 34'h2_45ff4500, 34'h2_4eff4e00, 34'h2_60ff6000,
    34'h2_beffbe00, 34'h2_c0ffc000, 34'h2_fdfffd00,
    34'h3_00ff0000, 34'h3_01ff0100, 34'h3_02ff0200, 34'h3_10ff1000,
    34'h3_46ff4600, 34'h3_47ff4700, 34'h3_feabfe6e, 34'h3_ff00ff93};

  //////////////////////////////////////////////////////////////////////////////
  // Identity values are arbitrary
  tfr_register_map #(.MAKER_ID(8'h6e), .REVISION(8'h93)) dut (
    .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .sample_strobe(sample_strobe), .local_temp_in(lt_in),
    .remote_temp_hi_in(rh_in), .remote_temp_lo_in(rl_in), .alert_status_in(st_in),
    .tach_count_lo_in(tl_in), .tach_count_hi_in(th_in), .duty_auto_in(du_in),
    .conversion_start(conversion_start), .standby(standby),
    .duty_override(duty_override), .duty_value(duty_value),
    .filter_level(filter_level), .alert_comparator_mode(alert_comparator_mode),
    .remote_low_limit_sign(remote_low_limit_sign),
    .remote_high_limit_fraction_msb(remote_high_limit_fraction_msb),
    .rw_image(rw_img), .lut_image(lut_img));

  tfr_host_model host (
    .mclk(mclk), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

  // 25 MHz clock
  always #20 mclk = ~mclk;

  // Run needs about 310 cycles; ceiling leaves ample margin
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      print_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(a, rd, hit);
    check(rd, exp);
  endtask : rd_chk

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    check(reg_rdata, 8'h00);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) host.write_reg(rows[i].wa, rows[i].wd);
      host.read_reg(rows[i].ra, rd, hit);
      check(rd, rows[i].exp);
      check({7'h00, hit}, {7'h00, rows[i].hit});
    end
    check({6'h00, filter_level}, 8'h03);
    check({7'h00, alert_comparator_mode}, 8'h01);
    check({7'h00, remote_low_limit_sign}, 8'h01);
    check({7'h00, remote_high_limit_fraction_msb}, 8'h01);
    check({7'h00, standby}, 8'h01);
    check({7'h00, duty_override}, 8'h01);
    check(duty_value, 8'h3f);
    check(rw_img[18*8 +: 8], 8'h07);
    check(lut_img[0 +: 8], 8'ha5);
    check(lut_img[15*8 +: 8], 8'h3c);
    // alias write reaches primary and sign output
    host.write_reg(8'h0e, 8'h7f);
    check({7'h00, remote_low_limit_sign}, 8'h00);
    rd_chk(8'h08, 8'h7f);
    host.write_reg(8'h0f, 8'h00);
    check({7'h00, conversion_start}, 8'h01);
    @(negedge mclk);
    check({7'h00, conversion_start}, 8'h00);
    host.write_reg(8'h09, 8'h00);
    check({7'h00, standby}, 8'h00);
    host.write_reg(8'h0f, 8'hff);
    check({7'h00, conversion_start}, 8'h00);
    @(negedge mclk);
    {lt_in, rh_in, rl_in, st_in} = 32'h9ce7ffff;
    {tl_in, th_in, du_in} = 24'h5bff2a;
    sample_strobe = 1'b1;
    @(negedge mclk);
    sample_strobe = 1'b0;
    rd_chk(8'h00, 8'h9c);
    rd_chk(8'h01, 8'he7);
    rd_chk(8'h10, 8'he0);
    rd_chk(8'h02, 8'hdf);
    rd_chk(8'h46, 8'h5b);
    rd_chk(8'h47, 8'h3f);
    rd_chk(8'h4c, 8'h3f);
    host.write_reg(8'h00, 8'h11);
    rd_chk(8'h00, 8'h9c);
    // Without override a host write to the duty byte is dropped
    host.write_reg(8'h4a, 8'h00);
    check({7'h00, duty_override}, 8'h00);
    host.write_reg(8'h4c, 8'h11);
    rd_chk(8'h4c, 8'h3f);
    @(negedge mclk);
    sample_strobe = 1'b1;
    @(negedge mclk);
    sample_strobe = 1'b0;
    rd_chk(8'h4c, 8'h2a);
    // Clock enable low freezes the map
    @(negedge mclk);
    clk_en = 1'b0;
    host.write_reg(8'h05, 8'h00);
    clk_en = 1'b1;
    rd_chk(8'h05, 8'ha5);
    // Reset in mid-run restores defaults, read back through two alias addresses and the duty byte
    @(negedge mclk);
    reset_n = 1'b0;
    #1;
    check(reg_rdata, 8'h00);
    @(negedge mclk);
    reset_n = 1'b1;
    rd_chk(8'h0e, 8'h00);
    rd_chk(8'h0b, 8'h46);
    rd_chk(8'h4c, 8'h00);
    print_verdict();
  end
endmodule : tfr_register_map_tb_top
